// ---- hdl/ppl_pkg.sv ----
package ppl_pkg;
  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int CFG_LOW_US      = 2;     // Least request low width
  localparam int ST2CK_US        = 2;     // Status high to first clock rise
  localparam int CF2CK_US        = 1506;  // Request high to first clock rise
  localparam int STATUS_LOW_MAX_US = 1506;
  localparam int CFG_LOW_CYC     = (CFG_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST2CK_CYC       = (ST2CK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CF2CK_CYC       = (CF2CK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_TO_CYC   = (STATUS_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int CFG_CLK_HALF    = 2;     // Ref cycles per cfg_clock half period
  localparam int POST_EDGES      = 2;     // Falling edges after load_complete
  localparam int CNT_W           = 16;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [6:0] {
    PPL_IDLE  = 7'b0000001,
    PPL_REQ   = 7'b0000010,
    PPL_WAIT  = 7'b0000100,
    PPL_LOAD  = 7'b0001000,
    PPL_POST  = 7'b0010000,
    PPL_DONE  = 7'b0100000,
    PPL_FAIL  = 7'b1000000
  } ppl_state_t;

  typedef struct packed {
    logic        wide;       // 1 = 16-bit bus
    logic        decompress;
    logic        secure;
    logic        monitor;    // Watch the status line
  } ppl_mode_t;

  typedef struct packed {
    logic        config_request_n;
    logic        cfg_clock;
    logic [15:0] data;
  } ppl_pins_t;

  // Clock cycles per word
  function automatic logic [2:0] ppl_ratio(input ppl_mode_t m);
    if (m.decompress)
      ppl_ratio = m.wide ? 3'h4 : 3'h2;
    else if (m.wide && m.secure)
      ppl_ratio = 3'h2;
    else
      ppl_ratio = 3'h1;
  endfunction : ppl_ratio
endpackage : ppl_pkg

// ---- hdl/ppl_sync.sv ----
module ppl_sync
  import ppl_pkg::*;
#(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Signals
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // ---------------------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ppl_sync

// ---- hdl/ppl_host.sv ----
// Behaviour
// RL1 - 8-bit bus: one clock per word, two with decompression.
// RL2 - 16-bit bus: one, two with security only, four with decompression.
// RL3 - User mode has all three lines high; driving request low restarts.
// RL4 - Device holds status low through its power-on delay.
// RL5 - Load-complete stays low until all data accepted.
// RL6 - Data sits on low sixteen or low eight lines.
// RL7 - Host sends whole image; device raises load-complete afterwards.
// RL8 - Host gives two more falling clock edges after load-complete rises.
// RL9 - After completion clock is ignored; host holds it at a level.
// RL10 - Init-complete output low until initialization finishes, if enabled.
// RL11 - Host may pause clock low; data valid before next rising edge.
// RL12 - Device drops load-complete and status within 600 ns of request low.
// RL13 - Host holds request low at least 2 us.
// RL14 - Device holds status low 268 to 1,506 us.
// RL15 - Device releases status within 1,506 us of request high.
// RL16 - First clock rise 2 us after status high, else 1,506 us after request.
// RL17 - Internal oscillator: user mode 175 to 437 us after load-complete.
// RL18 - User init clock enabled four clock periods after load-complete.
// RL19 - Configuration clock never faster than 125 MHz.
// RL20 - Data word stays stable over all clocks of that word.
module ppl_host
  import ppl_pkg::*;
#(
  parameter int CF2CK_CYCLES  = CF2CK_CYC,
  parameter int STATUS_CYCLES = STATUS_TO_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // User side
  input  wire logic        start,
  input  wire ppl_mode_t   mode,
  input  wire logic [15:0] word_data,
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic        word_last,
  output logic             busy,
  output logic             done,
  output logic             error,
  // Device pins
  output ppl_pins_t        pins,
  input  wire logic        status_n,
  input  wire logic        load_complete,
  input  wire logic        init_complete
);
  ppl_state_t  state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] tmo;
  logic [2:0]  ratio;
  logic [2:0]  beat;
  logic [1:0]  half;
  logic [1:0]  edges;
  logic        last_word;
  logic        status_s;
  logic        lc_s;
  logic        id_s;
  logic        clk_rise;
  logic        clk_fall;
  // Pin registers kept apart so that each one has a single writing process
  logic        config_request_n;
  logic        cfg_clock;
  logic [15:0] pin_data;

  ppl_sync #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({status_n, load_complete, init_complete}),
    .sync_out ({status_s, lc_s, id_s})
  );

  // ---------------------------------------------------------------------------
  // Clock divider: 4 ref cycles per cfg_clock period, 5 MHz well under 125 MHz
  // ---------------------------------------------------------------------------
  wire clk_run = (state == PPL_LOAD && (word_valid || beat != 3'h0)) || state == PPL_POST;
  assign clk_rise = clk_run && !cfg_clock && half == 2'(CFG_CLK_HALF - 1);
  assign clk_fall = cfg_clock && half == 2'(CFG_CLK_HALF - 1);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      half <= 2'h0;
      cfg_clock <= 1'b0;
    end else if (clk_rise || clk_fall) begin
      half <= 2'h0;
      cfg_clock <= !cfg_clock;              // RL19
    end else if (clk_run || cfg_clock) begin
      half <= half + 2'h1;
    end else begin
      half <= 2'h0;                         // RL11 pause with clock low
    end
  end

  // Word is taken when its last clock rises
  assign word_ready = state == PPL_LOAD && clk_rise && beat == ratio - 3'h1;

  // ---------------------------------------------------------------------------
  // Sequence control
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= PPL_IDLE;
      cnt   <= '0;
      tmo   <= '0;
      ratio <= 3'h1;
      beat  <= 3'h0;
      edges <= 2'h0;
      last_word <= 1'b0;
      config_request_n <= 1'b1;
      pin_data <= DATA_RST;
      done  <= 1'b0;
      error <= 1'b0;
    end else begin
      unique case (state)
        PPL_IDLE: begin
          if (start) begin
            ratio <= ppl_ratio(mode);                      // RL1 RL2
            config_request_n <= 1'b0;                      // RL3
            cnt   <= '0;
            done  <= 1'b0;
            error <= 1'b0;
            last_word <= 1'b0;
            state <= PPL_REQ;
          end
        end
        PPL_REQ: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(CFG_LOW_CYC - 1)) begin       // RL13
            config_request_n <= 1'b1;
            cnt <= '0;
            tmo <= '0;
            state <= PPL_WAIT;
          end
        end
        PPL_WAIT: begin
          // RL16 gap before first rise; status seen low restarts the count
          tmo <= tmo + 1'b1;
          if (mode.monitor && !status_s) begin
            cnt <= '0;
            if (tmo == CNT_W'(STATUS_CYCLES))              // RL15
              state <= PPL_FAIL;
          end else begin
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(mode.monitor ? ST2CK_CYC - 1 : CF2CK_CYCLES - 1)) begin
              beat  <= 3'h0;
              state <= PPL_LOAD;                           // RL16
            end
          end
        end
        PPL_LOAD: begin
          if (mode.monitor && !status_s) begin
            state <= PPL_FAIL;
          end else if (beat == 3'h0 && word_valid && !clk_run) begin
            state <= PPL_LOAD;
          end else begin
            if (beat == 3'h0 && word_valid && !cfg_clock && half == 2'h0) begin
              // RL6 narrow bus uses low byte only
              pin_data <= mode.wide ? word_data : {8'h00, word_data[7:0]};
              last_word <= word_last;
            end
            if (clk_rise) begin
              if (beat == ratio - 3'h1) begin              // RL20
                beat <= 3'h0;
                if (last_word) begin                       // RL7
                  edges <= 2'h0;
                  state <= PPL_POST;
                end
              end else begin
                beat <= beat + 3'h1;
              end
            end
          end
        end
        PPL_POST: begin
          if (clk_fall && lc_s) begin
            edges <= edges + 2'h1;
            if (edges == 2'(POST_EDGES - 1))               // RL8
              state <= PPL_DONE;
          end
        end
        PPL_DONE: begin
          pin_data <= DATA_RST;                            // RL9 clock parked low
          // Init clock is left to the device; only its completion is awaited
          if (id_s) begin                                  // RL18
            done  <= 1'b1;                                 // RL10
            state <= PPL_IDLE;
          end
        end
        PPL_FAIL: begin
          error <= 1'b1;
          pin_data <= DATA_RST;
          state <= PPL_IDLE;
        end
        default: state <= PPL_IDLE;
      endcase
    end
  end

  assign busy = state != PPL_IDLE;
  assign pins = '{config_request_n: config_request_n, cfg_clock: cfg_clock, data: pin_data};
endmodule : ppl_host

// ---- dv/ppl_host_asserts.sv ----
module ppl_host_asserts
  import ppl_pkg::*;
#(
  parameter int CF2CK_CYCLES  = CF2CK_CYC,
  parameter int STATUS_CYCLES = STATUS_TO_CYC
) (
  // Clock, reset and user side
  input wire logic        ref_clk, reset, start, word_valid, word_ready, word_last, busy, done, error,
  input wire ppl_mode_t   mode,
  input wire logic [15:0] word_data,
  // Device pins
  input wire ppl_pins_t   pins,
  input wire logic        status_n, load_complete, init_complete
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_req_width: assert property ($rose(pins.config_request_n) |-> !$past(pins.config_request_n, 40))
    else $error("request low too short");
  a_quiet_req: assert property (!pins.config_request_n |-> !pins.cfg_clock)
    else $error("clock moved during request");
  a_start_req: assert property (start && !busy |=> !pins.config_request_n)
    else $error("start did not drop request");
  a_ready_rise: assert property (word_ready |=> $rose(pins.cfg_clock))
    else $error("word taken without clock rise");
  a_clk_shape: assert property ($rose(pins.cfg_clock) |-> ##1 pins.cfg_clock ##1 !pins.cfg_clock)
    else $error("clock high time wrong");
  a_data_setup: assert property ($rose(pins.cfg_clock) |-> $stable(pins.data))
    else $error("data moved at clock rise");
  a_narrow_bus: assert property (busy && !mode.wide |-> pins.data[15:8] == 8'h00)
    else $error("upper lines driven in narrow mode");
  a_clk_hold: assert property (done && !start |=> $stable(pins.cfg_clock))
    else $error("clock toggles after completion");
endmodule : ppl_host_asserts

bind ppl_host ppl_host_asserts #(.CF2CK_CYCLES(CF2CK_CYCLES), .STATUS_CYCLES(STATUS_CYCLES)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .start(start), .word_valid(word_valid), .word_ready(word_ready),
  .word_last(word_last), .busy(busy), .done(done), .error(error), .mode(mode), .word_data(word_data),
  .pins(pins), .status_n(status_n), .load_complete(load_complete), .init_complete(init_complete));

// ---- dv/ppl_dev_model.sv ----
module ppl_dev_model
  import ppl_pkg::*;
(
  // Host pins
  input wire logic      ref_clk,
  input wire ppl_pins_t pins,
  // Device lines
  output logic          status_n, load_complete, init_complete
);
  timeunit 1ns;
  timeprecision 1ns;
  int          need = 4, rises = 0, falls = 0, st_cnt = 0;
  logic        hold_low = 1'b0, ck_q = 1'b0;
  logic [15:0] last_data = 16'h0000;
  initial {status_n, load_complete, init_complete} = 3'h0;
  always @(posedge ref_clk) begin
    ck_q <= pins.cfg_clock;
    if (pins.config_request_n === 1'b0) begin
      {status_n, load_complete, init_complete} <= 3'h0;
      {rises, falls, st_cnt} <= '0;
    end else begin
      st_cnt <= st_cnt + 1;
      if (st_cnt >= 30 && !hold_low) status_n <= 1'b1;
      // Edges before status release are lost, as on the real part
      if (pins.cfg_clock && !ck_q && status_n && !load_complete) begin
        rises <= rises + 1;
        last_data <= pins.data;
        load_complete <= (rises + 1 == need);
      end
      // Once in user mode the clock is ignored, so later falls are not counted
      if (!pins.cfg_clock && ck_q && load_complete && !init_complete) begin
        falls <= falls + 1;
        init_complete <= (falls >= 1);
      end
    end
  end
endmodule : ppl_dev_model

// ---- dv/tb.sv ----
module tb
  import ppl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, reset, start, word_valid, word_last, word_ready, busy, done, error;
  logic        status_n, load_complete, init_complete;
  logic [15:0] word_data;
  ppl_mode_t   mode;
  ppl_pins_t   pins;
  int          n_mismatch = 0, n_checks = 0;
  ppl_host #(.CF2CK_CYCLES(50), .STATUS_CYCLES(100)) i_dut (.ref_clk(ref_clk), .reset(reset), .start(start),
    .mode(mode), .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready), .word_last(word_last),
    .busy(busy), .done(done), .error(error), .pins(pins), .status_n(status_n), .load_complete(load_complete),
    .init_complete(init_complete));
  ppl_dev_model i_dev (.ref_clk(ref_clk), .pins(pins), .status_n(status_n), .load_complete(load_complete),
    .init_complete(init_complete));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic wait_hi(ref logic s);
    int g = 0;
    while (s !== 1'b1 && g < 3000) begin
      @(negedge ref_clk);
      g++;
    end
  endtask : wait_hi
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic run_load(input ppl_mode_t m, input bit pause);
    int r;
    r = m.decompress ? (m.wide ? 4 : 2) : ((m.wide && m.secure) ? 2 : 1);
    i_dev.need = 3 * r;
    mode = m;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(load_complete, 1'b0);
    check(pins.config_request_n, 1'b0);
    for (int k = 0; k < 3; k++) begin
      word_data = 16'h5ac3 + 16'(k);
      word_last = (k == 2);
      word_valid = !(pause && k == 1);
      // Stall the stream so the clock must park low
      if (pause && k == 1) begin
        repeat (20) @(negedge ref_clk);
        word_valid = 1'b1;
      end
      wait_hi(word_ready);
      @(negedge ref_clk);
    end
    word_valid = 1'b0;
    wait_hi(done);
    check(16'(i_dev.rises), 16'(3 * r));
    check(i_dev.last_data, m.wide ? 16'h5ac5 : 16'h00c5);
    check(16'(i_dev.falls), 16'h2);
    check({done, error}, 2'b10);
  endtask : run_load
  task automatic run_stuck();
    i_dev.hold_low = 1'b1;
    mode = 4'h1;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    wait_hi(error);
    check(error, 1'b1);
    check(16'(i_dev.rises), 16'h0);
    i_dev.hold_low = 1'b0;
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    check({busy, error, pins.config_request_n}, 3'b001);
  endtask : run_stuck
  initial begin
    {reset, start, word_valid, word_last} = 4'h8;
    mode = 4'h0;
    word_data = 16'h0000;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) run_load(ppl_mode_t'({i[2], i[1], i[0], i[0] ^ i[2]}), i[1]);
    run_stuck();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb
